/* logic/cfg_loader_pkg.sv */
package cfg_loader_pkg;

  // pclk rate
  localparam int CLK_MHZ = 50;

  // power-on reset hold of the status line
  localparam int POR_US = 12000;
  localparam int POR_CYC = POR_US * CLK_MHZ;

  // least low time of the status line in reset
  localparam int STATUS_MIN_US = 10;
  localparam int STATUS_MIN_CYC = STATUS_MIN_US * CLK_MHZ;

  // reset time-out after an error with automatic restart
  localparam int RESTART_US = 50;
  localparam int RESTART_CYC = RESTART_US * CLK_MHZ;

  // initialization oscillator derived from pclk
  localparam int OSC_MHZ = 10;
  localparam int OSC_DIV = CLK_MHZ / OSC_MHZ;
  localparam int INIT_US = 50;
  localparam int INIT_TICKS = INIT_US * OSC_MHZ;

  // delay from entering initialization to enabling the user start-up clock
  localparam int USR_EN_NS = 600;
  localparam int USR_EN_CYC = (USR_EN_NS * CLK_MHZ + 999) / 1000;
  localparam int USR_INIT_CLOCKS = 4436;

  // active serial link
  localparam logic [2:0] SCHEME_AS = 3'h3;
  localparam logic [7:0] AS_READ_CMD = 8'h03;
  localparam logic [2:0] AS_HALF = 3'h3;
  localparam logic [5:0] AS_HDR_FALLS = 6'h21;

  // register offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_LEN = 12'h004;
  localparam logic [11:0] REG_STAT = 12'h008;
  localparam logic [11:0] REG_COUNT = 12'h00c;

  // control fields
  localparam int CTRL_RESTART = 0;
  localparam int CTRL_USRCLK = 1;
  localparam int CTRL_DECOMP = 2;
  localparam int CTRL_DECRYPT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [31:0] LEN_RESET = 32'h0000_0100;

  typedef enum logic [3:0] {
    ST_POR, ST_RESET, ST_RELEASE, ST_CONFIG, ST_ERROR,
    ST_WAIT_DONE, ST_EDGES, ST_INIT, ST_USER
  } state_t;

endpackage : cfg_loader_pkg

/* logic/pin_sync_if.sv */
`timescale 1ns/1ps
interface pin_sync_if #(parameter int W = 1);
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : pin_sync_if

/* logic/sync_filter.sv */
`timescale 1ns/1ps
module sync_filter #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] raw,
  pin_sync_if.src sync
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] agree;
  logic [W-1:0] next_level;

  // a change counts once the second and third stages agree
  assign agree = ~(s2 ^ s3);
  assign next_level = (agree & s3) | (~agree & sync.level);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      sync.level <= '0;
      sync.rise <= '0;
      sync.fall <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      sync.level <= next_level;
      sync.rise <= next_level & ~sync.level;
      sync.fall <= ~next_level & sync.level;
    end
  end

endmodule : sync_filter

/* logic/cfg_loader.sv */
// Contract
// - in user mode all lines high; request low starts reconfiguration
// - status line held low through the power-on reset delay
// - load-complete line low from power-up until all data accepted
// - request low pulls load-complete and status low within 800 ns
// - status low pulse lasts 10 to 100 us
// - status released within 100 us after request rises
// - two clock falls after load complete before initialization starts; the active serial scheme starts initialization without them
// - internal oscillator start-up enters user mode 20 to 100 us later
// - user start-up clock enabled no sooner than four clock periods
// - user start-up option enters user mode after 4436 user clocks
// - byte-bus pins handed to user logic after configuration
// - active serial scheme masters the flash and loads its data
// - scheme select low, high, high chooses active serial
// - decompression and decryption available in active serial scheme
// - four flash signals: clock, data, command line, select low
// - after error with auto restart, release status within 100 us
// - initialization clocked by separate 10 MHz oscillator by default; here a 10 MHz tick divided from pclk
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
module cfg_loader #(
  parameter int POR_CYCLES = cfg_loader_pkg::POR_CYC,
  parameter int USR_INIT_COUNT = cfg_loader_pkg::USR_INIT_CLOCKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cfg_request_n,
  input wire logic status_in,
  output logic status_out,
  output logic status_oe_n,
  input wire logic done_in,
  output logic done_out,
  output logic done_oe_n,
  input wire logic cfg_clock,
  input wire logic [7:0] cfg_data,
  input wire logic user_startup_clock,
  input wire logic [2:0] scheme_select,
  output logic flash_clk,
  input wire logic flash_data,
  output logic flash_cmd_in,
  output logic flash_select_n,
  input wire logic image_error,
  output logic [7:0] cfg_byte,
  output logic cfg_byte_valid,
  output logic cfg_decompress,
  output logic cfg_decrypt,
  output logic user_mode,
  output logic user_io_enable
);

  localparam int SW = 17;
  localparam logic [19:0] POR_LIM = 20'(POR_CYCLES);
  localparam logic [19:0] STATUS_LIM = 20'(cfg_loader_pkg::STATUS_MIN_CYC);
  localparam logic [19:0] RESTART_LIM = 20'(cfg_loader_pkg::RESTART_CYC);
  localparam logic [19:0] USR_EN_LIM = 20'(cfg_loader_pkg::USR_EN_CYC);
  localparam logic [12:0] USR_LIM = 13'(USR_INIT_COUNT);
  localparam logic [12:0] INIT_LIM = 13'(cfg_loader_pkg::INIT_TICKS);
  localparam logic [2:0] OSC_LIM = 3'(cfg_loader_pkg::OSC_DIV - 1);

  cfg_loader_pkg::state_t state;
  cfg_loader_pkg::state_t next_state;

  // synchronised pins
  logic [SW-1:0] pins_raw;
  pin_sync_if #(.W(SW)) pins();

  assign pins_raw = {scheme_select, user_startup_clock, flash_data, done_in,
                     status_in, cfg_request_n, cfg_clock, cfg_data};

  sync_filter #(.W(SW)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .raw(pins_raw),
    .sync(pins)
  );

  wire [7:0] data_lvl = pins.level[7:0];
  wire cfg_clk_rise = pins.rise[8];
  wire cfg_clk_fall = pins.fall[8];
  wire req_lvl = pins.level[9];
  wire stat_lvl = pins.level[10];
  wire done_lvl = pins.level[11];
  wire fdata_lvl = pins.level[12];
  wire uclk_rise = pins.rise[13];
  wire [2:0] scheme_lvl = pins.level[16:14];

  // registers
  logic [3:0] ctrl;
  logic [31:0] img_len;
  logic [31:0] byte_cnt;
  logic err_flag;
  logic as_mode;
  logic [19:0] timer;
  logic edge_cnt;
  logic [2:0] osc_cnt;
  logic [12:0] init_cnt;

  // active serial engine
  logic [2:0] as_div;
  logic [5:0] hdr_cnt;
  logic [2:0] bit_cnt;
  logic [31:0] cmd_sh;
  logic [6:0] as_sh;

  wire in_config = (state == cfg_loader_pkg::ST_CONFIG);
  wire in_init = (state == cfg_loader_pkg::ST_INIT);
  wire as_run = in_config & as_mode;
  wire as_half_tick = (as_div == cfg_loader_pkg::AS_HALF);
  wire as_fall = as_run & as_half_tick & flash_clk;
  wire as_sampling = (hdr_cnt == cfg_loader_pkg::AS_HDR_FALLS);
  wire as_byte_ok = as_fall & as_sampling & (bit_cnt == 3'h7);
  wire [7:0] as_byte = {as_sh, fdata_lvl};

  wire fpp_ok = in_config & ~as_mode & cfg_clk_rise & stat_lvl;
  wire byte_ok = as_mode ? as_byte_ok : fpp_ok;
  wire [7:0] byte_val = as_mode ? as_byte : data_lvl;
  wire byte_last = ((byte_cnt + 32'h1) == img_len);

  wire osc_tick = (osc_cnt == OSC_LIM);
  wire usr_opt = ctrl[cfg_loader_pkg::CTRL_USRCLK];
  wire usr_en = usr_opt & in_init & (timer >= USR_EN_LIM);
  wire init_done = usr_opt ? (init_cnt == USR_LIM) : (init_cnt == INIT_LIM);

  always_comb begin
    next_state = state;
    unique case (state)
      cfg_loader_pkg::ST_POR:
        if (timer >= POR_LIM) next_state = cfg_loader_pkg::ST_RELEASE;
      cfg_loader_pkg::ST_RESET:
        if (req_lvl && timer >= STATUS_LIM) begin
          next_state = cfg_loader_pkg::ST_RELEASE;
        end
      cfg_loader_pkg::ST_RELEASE:
        if (stat_lvl) next_state = cfg_loader_pkg::ST_CONFIG;
      cfg_loader_pkg::ST_CONFIG:
        if (image_error) begin
          next_state = cfg_loader_pkg::ST_ERROR;
        end else if (byte_ok && byte_last) begin
          next_state = cfg_loader_pkg::ST_WAIT_DONE;
        end
      cfg_loader_pkg::ST_ERROR:
        if (ctrl[cfg_loader_pkg::CTRL_RESTART] && timer >= RESTART_LIM) begin
          next_state = cfg_loader_pkg::ST_RELEASE;
        end
      cfg_loader_pkg::ST_WAIT_DONE:
        if (done_lvl) begin
          next_state = as_mode ? cfg_loader_pkg::ST_INIT
                               : cfg_loader_pkg::ST_EDGES;
        end
      cfg_loader_pkg::ST_EDGES:
        if (cfg_clk_fall && edge_cnt) next_state = cfg_loader_pkg::ST_INIT;
      cfg_loader_pkg::ST_INIT:
        if (init_done) next_state = cfg_loader_pkg::ST_USER;
      cfg_loader_pkg::ST_USER: ;
    endcase
    if (state != cfg_loader_pkg::ST_POR && !req_lvl) begin
      next_state = cfg_loader_pkg::ST_RESET;
    end
  end

  wire drive_status = (next_state == cfg_loader_pkg::ST_POR) |
                      (next_state == cfg_loader_pkg::ST_RESET) |
                      (next_state == cfg_loader_pkg::ST_ERROR);
  wire release_done = (next_state == cfg_loader_pkg::ST_WAIT_DONE) |
                      (next_state == cfg_loader_pkg::ST_EDGES) |
                      (next_state == cfg_loader_pkg::ST_INIT) |
                      (next_state == cfg_loader_pkg::ST_USER);
  wire to_user = (next_state == cfg_loader_pkg::ST_USER);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= cfg_loader_pkg::ST_POR;
      timer <= '0;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        timer <= '0;
      end else if (timer != '1) begin
        timer <= timer + 20'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_oe_n <= 1'b0;
      done_oe_n <= 1'b0;
      status_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      status_oe_n <= ~drive_status;
      done_oe_n <= release_done;
      status_out <= 1'b0;
      done_out <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      user_mode <= 1'b0;
      user_io_enable <= 1'b0;
    end else begin
      user_mode <= to_user;
      user_io_enable <= to_user;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      as_mode <= 1'b0;
    end else if (state == cfg_loader_pkg::ST_RELEASE) begin
      as_mode <= (scheme_lvl == cfg_loader_pkg::SCHEME_AS);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_cnt <= '0;
      cfg_byte <= '0;
      cfg_byte_valid <= 1'b0;
    end else begin
      cfg_byte_valid <= byte_ok;
      if (state == cfg_loader_pkg::ST_RELEASE) begin
        byte_cnt <= '0;
      end else if (byte_ok) begin
        byte_cnt <= byte_cnt + 32'h1;
        cfg_byte <= byte_val;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_decompress <= 1'b0;
      cfg_decrypt <= 1'b0;
    end else begin
      cfg_decompress <= ctrl[cfg_loader_pkg::CTRL_DECOMP];
      cfg_decrypt <= ctrl[cfg_loader_pkg::CTRL_DECRYPT];
    end
  end

  // error flag: a new error outranks the clear at reload
  wire err_set = in_config & image_error;
  wire err_clr = (state == cfg_loader_pkg::ST_RELEASE) & stat_lvl;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_flag <= 1'b0;
    end else begin
      err_flag <= err_set | (err_flag & ~err_clr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_cnt <= 1'b0;
    end else if (state != cfg_loader_pkg::ST_EDGES) begin
      edge_cnt <= 1'b0;
    end else if (cfg_clk_fall) begin
      edge_cnt <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt <= '0;
    end else begin
      osc_cnt <= osc_tick ? 3'h0 : osc_cnt + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_cnt <= '0;
    end else if (!in_init) begin
      init_cnt <= '0;
    end else if (usr_opt ? (usr_en & uclk_rise) : osc_tick) begin
      init_cnt <= init_cnt + 13'h1;
    end
  end

  // flash master; shifts and samples on falling edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_clk <= 1'b1;
      flash_select_n <= 1'b1;
      flash_cmd_in <= 1'b1;
      as_div <= '0;
      hdr_cnt <= '0;
      bit_cnt <= '0;
      cmd_sh <= '0;
      as_sh <= '0;
    end else if (!as_run) begin
      flash_clk <= 1'b1;
      flash_select_n <= 1'b1;
      flash_cmd_in <= 1'b1;
      as_div <= '0;
      hdr_cnt <= '0;
      bit_cnt <= '0;
      cmd_sh <= {cfg_loader_pkg::AS_READ_CMD, 24'h000000};
    end else begin
      flash_select_n <= 1'b0;
      as_div <= as_half_tick ? 3'h0 : as_div + 3'h1;
      if (as_half_tick) flash_clk <= ~flash_clk;
      if (as_fall && !as_sampling) begin
        hdr_cnt <= hdr_cnt + 6'h1;
        flash_cmd_in <= cmd_sh[31];
        cmd_sh <= {cmd_sh[30:0], 1'b0};
      end else if (as_fall) begin
        as_sh <= as_byte[6:0];
        bit_cnt <= bit_cnt + 3'h1;
      end
    end
  end

  // apb slave, zero wait states
  wire apb_setup = psel & ~penable;
  wire apb_write = psel & penable & pready & pwrite & ~pslverr;
  wire hit_ctrl = (paddr == cfg_loader_pkg::REG_CTRL);
  wire hit_len = (paddr == cfg_loader_pkg::REG_LEN);
  wire hit_stat = (paddr == cfg_loader_pkg::REG_STAT);
  wire hit_count = (paddr == cfg_loader_pkg::REG_COUNT);
  wire addr_ok = hit_ctrl | hit_len | hit_stat | hit_count;
  wire [31:0] stat_word = {25'h0, err_flag, as_mode, user_mode, 4'(state)};
  wire [31:0] rd_val = hit_ctrl ? {28'h0, ctrl} :
                       hit_len ? img_len :
                       hit_stat ? stat_word :
                       hit_count ? byte_cnt : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= apb_setup;
      if (apb_setup) begin
        pslverr <= ~addr_ok;
        prdata <= pwrite ? 32'h0 : rd_val;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= cfg_loader_pkg::CTRL_RESET;
      img_len <= cfg_loader_pkg::LEN_RESET;
    end else if (apb_write) begin
      if (hit_ctrl) ctrl <= pwdata[3:0];
      if (hit_len) img_len <= pwdata;
    end
  end

endmodule : cfg_loader

/* tb/cfg_host_model.sv */
`timescale 1ns/1ps
module cfg_host_model (
  input wire logic pclk,
  output logic cfg_clock,
  output logic [7:0] cfg_data
);
  initial begin
    cfg_clock = 1'b0;
    cfg_data = 8'h00;
  end
  // clock rests low, byte set up first
  task send(input logic [7:0] b);
    @(posedge pclk);
    cfg_data <= b;
    repeat (2) @(posedge pclk);
    cfg_clock <= 1'b1;
    repeat (4) @(posedge pclk);
    cfg_clock <= 1'b0;
    repeat (2) @(posedge pclk);
    cfg_data <= ~b;
  endtask : send
endmodule : cfg_host_model

/* tb/cfg_loader_assertions.sv */
`timescale 1ns/1ps
module cfg_loader_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cfg_request_n,
  input wire logic status_oe_n,
  input wire logic done_oe_n,
  input wire logic cfg_byte_valid,
  input wire logic user_mode,
  input wire logic user_io_enable,
  input wire logic [2:0] scheme_select,
  input wire logic flash_select_n
);
  logic req_seen;
  logic armed;
  logic [15:0] lo_cnt;
  logic [15:0] arm_cnt;
  logic [15:0] cd_cnt;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_seen <= 1'b0;
      armed <= 1'b0;
      lo_cnt <= 16'h0;
      arm_cnt <= 16'h0;
      cd_cnt <= 16'h0;
    end else begin
      req_seen <= req_seen | ~cfg_request_n;
      armed <= ~status_oe_n & (armed | $rose(cfg_request_n));
      lo_cnt <= status_oe_n ? 16'h0 : lo_cnt + 16'h1;
      arm_cnt <= armed ? arm_cnt + 16'h1 : 16'h0;
      cd_cnt <= done_oe_n ? cd_cnt + 16'h1 : 16'h0;
    end
  end
  property p_req_low;
    $fell(cfg_request_n) |-> ##[1:40] (!status_oe_n && !done_oe_n);
  endproperty
  a_req_low: assert property (p_req_low)
    else $error("request low not followed by low lines");
  property p_status_min;
    $rose(status_oe_n) && req_seen |-> lo_cnt >= 16'h01f4;
  endproperty
  a_status_min: assert property (p_status_min)
    else $error("status low pulse too short");
  property p_release;
    arm_cnt <= 16'h1388;
  endproperty
  a_release: assert property (p_release)
    else $error("status not released in time");
  property p_done_low;
    !status_oe_n |-> !done_oe_n;
  endproperty
  a_done_low: assert property (p_done_low)
    else $error("done released while status low");
  property p_user;
    $rose(user_mode) |-> status_oe_n && done_oe_n;
  endproperty
  a_user: assert property (p_user)
    else $error("user mode with a line held low");
  property p_io;
    user_io_enable |-> done_oe_n;
  endproperty
  a_io: assert property (p_io)
    else $error("byte pins handed over before done");
  property p_byte;
    cfg_byte_valid |-> $past(status_oe_n) && !$past(done_oe_n);
  endproperty
  a_byte: assert property (p_byte)
    else $error("byte accepted outside loading");
  property p_init;
    $rose(user_mode) |-> cd_cnt >= 16'h001e;
  endproperty
  a_init: assert property (p_init)
    else $error("user mode too soon after done");
  property p_scheme;
    scheme_select != 3'h3 |-> flash_select_n;
  endproperty
  a_scheme: assert property (p_scheme)
    else $error("flash selected in parallel scheme");
endmodule : cfg_loader_checker

bind cfg_loader cfg_loader_checker u_chk (.pclk(pclk), .presetn(presetn),
  .cfg_request_n(cfg_request_n), .status_oe_n(status_oe_n),
  .done_oe_n(done_oe_n), .cfg_byte_valid(cfg_byte_valid),
  .user_mode(user_mode), .user_io_enable(user_io_enable),
  .scheme_select(scheme_select), .flash_select_n(flash_select_n));

/* tb/test_fpga_config_loader.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
  end \
end
`define WAITC(c, lim) begin \
  n = 0; \
  while (!(c) && n < lim) begin \
    @(negedge pclk); \
    n++; \
  end \
end
module test_fpga_config_loader;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, er;
  logic flash_data, image_error;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic cfg_request_n, status_out, status_oe_n, done_out, done_oe_n;
  logic cfg_clock, flash_clk, flash_cmd_in, flash_select_n;
  logic cfg_byte_valid, cfg_decompress, cfg_decrypt;
  logic user_mode, user_io_enable;
  logic [7:0] cfg_data, cfg_byte, cmd;
  logic [2:0] scheme_select;
  logic [7:0] got[$];
  logic [7:0] img[4] = '{8'ha5, 8'h3c, 8'h00, 8'hff};
  int fails, samples_checked, n, t, cyc;
  // open-drain wires with pull-ups
  wire status_w = status_oe_n ? 1'b1 : status_out;
  wire done_w = done_oe_n ? 1'b1 : done_out;
  always #10 pclk = ~pclk;
  cfg_loader #(.POR_CYCLES(200), .USR_INIT_COUNT(20)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cfg_request_n, .status_in(status_w), .status_out,
    .status_oe_n, .done_in(done_w), .done_out, .done_oe_n, .cfg_clock,
    .cfg_data, .user_startup_clock(1'b0), .scheme_select, .flash_clk,
    .flash_data, .flash_cmd_in, .flash_select_n,
    .image_error, .cfg_byte, .cfg_byte_valid, .cfg_decompress,
    .cfg_decrypt, .user_mode, .user_io_enable);
  cfg_host_model u_host (.pclk(pclk), .cfg_clock(cfg_clock),
    .cfg_data(cfg_data));
  always @(posedge pclk) begin
    if (cfg_byte_valid === 1'b1) got.push_back(cfg_byte);
    cyc++;
    if (cyc == 40000) begin
      fails++;
      final_report();
    end
  end
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task tend(input string s);
    $display("test %s done", s);
  endtask : tend
  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    cfg_request_n = 1'b1;
    scheme_select = 3'h0;
    // flash data idles at its pull-up level
    flash_data = 1'b1;
    image_error = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (150) @(negedge pclk);
    `CHK("por_status", 1'b0, status_oe_n)
    `CHK("por_done", 1'b0, done_oe_n)
    `WAITC(status_oe_n === 1'b1, 400)
    `CHK("por_release", 1'b1, status_oe_n)
    tend("power_on");
    apb(1'b0, cfg_loader_pkg::REG_LEN, 32'h0);
    `CHK("len_reset", cfg_loader_pkg::LEN_RESET, rd)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped_err", 1'b1, er)
    apb(1'b1, cfg_loader_pkg::REG_LEN, 32'h4);
    apb(1'b1, cfg_loader_pkg::REG_CTRL, 32'hc);
    apb(1'b0, cfg_loader_pkg::REG_LEN, 32'h0);
    `CHK("len_rw", 32'h4, rd)
    @(negedge pclk);
    `CHK("decomp", 2'h3, {cfg_decompress, cfg_decrypt})
    tend("registers");
    // wait after status high before first rise
    repeat (100) @(posedge pclk);
    foreach (img[i]) u_host.send(img[i]);
    @(negedge pclk);
    `WAITC(done_oe_n === 1'b1, 50)
    `CHK("done_rel", 1'b1, done_oe_n)
    `CHK("byte_cnt", 4, got.size())
    foreach (img[i]) `CHK("byte", img[i], got[i])
    repeat (200) @(negedge pclk);
    `CHK("no_init", 1'b0, user_mode)
    repeat (2) u_host.send(8'h00);
    `WAITC(user_mode === 1'b1, 6000)
    t = n + 216;
    `CHK("init_time", 1'b1, t >= 1000 && t <= 5000)
    `CHK("user_io", 1'b1, user_io_enable)
    `CHK("user_lines", 2'h3, {status_w, done_w})
    tend("parallel_load");
    @(posedge pclk);
    scheme_select <= 3'h3;
    cfg_request_n <= 1'b0;
    @(negedge pclk);
    `WAITC(!status_oe_n && !done_oe_n, 60)
    `CHK("req_fast", 1'b1, n <= 40)
    `CHK("req_exit", 1'b0, user_mode)
    t = n;
    // request held low beyond 2 us
    repeat (150) @(posedge pclk);
    // no cfg_clock rise follows in the serial reload
    cfg_request_n <= 1'b1;
    @(negedge pclk);
    `WAITC(status_oe_n === 1'b1, 6000)
    `CHK("rel_time", 1'b1, n <= 5000)
    `CHK("low_pulse", 1'b1, t + n + 150 >= 500)
    tend("reconfigure");
    `WAITC(flash_select_n === 1'b0, 500)
    `CHK("flash_sel", 1'b0, flash_select_n)
    cmd = 8'h00;
    for (int i = 0; i < 8; i++) begin
      `WAITC(flash_clk === 1'b0, 40)
      `WAITC(flash_clk === 1'b1, 40)
      cmd = {cmd[6:0], flash_cmd_in};
    end
    `CHK("flash_cmd", cfg_loader_pkg::AS_READ_CMD, cmd)
    tend("active_serial");
    apb(1'b1, cfg_loader_pkg::REG_CTRL, 32'hd);
    @(posedge pclk);
    image_error <= 1'b1;
    @(posedge pclk);
    image_error <= 1'b0;
    @(negedge pclk);
    `CHK("err_status", 1'b0, status_oe_n)
    apb(1'b0, cfg_loader_pkg::REG_STAT, 32'h0);
    `CHK("err_stat", 32'h64, rd)
    `WAITC(status_oe_n === 1'b1, 6000)
    `CHK("restart_rel", 1'b1, n <= 5000)
    `WAITC(done_oe_n === 1'b1, 1000)
    repeat (2) @(negedge pclk);
    `CHK("as_done", 1'b1, done_oe_n)
    `CHK("as_cnt", 8, got.size())
    `CHK("as_byte", 8'hff, got[7])
    tend("error_restart");
    final_report();
  end
endmodule : test_fpga_config_loader
